//--- hdl/ccrx_device.sv
// Core end of the 256-bit receive packet stream: takes beats from the core's
// packet source, gates them by credits, adds parity and runs the link handshake.
// Assumes one clock shared with the application end and a synchronous reset.
`timescale 1ns/100ps
`default_nettype none
`include "ccrx_defines.svh"

module ccrx_device #(
    parameter int CREDIT_W = `CCRX_CREDIT_W
) (
    input wire logic mclk, // Clock
    input wire logic sys_rst, // Sync reset, high
    ccrx_if.dev bus, // Stream to application
    input wire logic link_enable, // Core wants the link up
    input wire logic src_valid, // Source beat present
    output logic src_ready, // Source beat taken
    input wire logic [`CCRX_DATA_W-1:0] src_data, // Beat data
    input wire logic [1:0] src_start_flags, // Start code
    input wire logic src_first_pos, // First start at byte 16
    input wire logic src_second_pos, // Second start at byte 16
    input wire logic [1:0] src_end_flags, // End code
    input wire logic [2:0] src_end0_offset, // First end dword
    input wire logic [2:0] src_end1_offset, // Second end dword
    input wire logic [1:0] src_abort, // Corruption seen
    output logic link_active, // Link in active state
    output logic [CREDIT_W-1:0] credit_level // Unused credits held
);
    ccrx_pkg::ccrx_dev_state_t st;
    ccrx_pkg::ccrx_dev_state_t next_st;
    logic [`CCRX_BYTES-1:0] src_par;

    // Packets counted by a start or end code; reserved 10 counts none
    function automatic logic [1:0] code_count(input logic [1:0] code);
        case (code)
            `CCRX_CODE_ONE: code_count = 2'h1;
            `CCRX_CODE_TWO: code_count = 2'h2;
            default: code_count = 2'h0;
        endcase
    endfunction

    // Link states in which beats may still flow
    function automatic logic link_flowing(input ccrx_pkg::ccrx_link_t link);
        link_flowing = (link == ccrx_pkg::CCRX_ACTIVE) || (link == ccrx_pkg::CCRX_DRAIN);
    endfunction

    genvar gi;
    generate
        for (gi = 0; gi < `CCRX_BYTES; gi++) begin : g_par
            assign src_par[gi] = ~^src_data[gi*8 +: 8];
        end
    endgenerate

    always_comb begin
        logic take;
        logic [1:0] starts;
        logic [1:0] ends;
        logic [2:0] open_sum;
        logic [CREDIT_W-1:0] cred;
        logic wide_open;
        // Beat taken on the edge where valid meets ready
        take = src_valid && st.src_ready;
        starts = code_count(src_start_flags);
        ends = code_count(src_end_flags);
        open_sum = 3'h0;
        cred = st.credits;
        wide_open = 1'b0;
        next_st = st;
        next_st.valid = 1'b0;
        next_st.credit_rtn = 1'b0;
        next_st.user = '0;

        // Saturates rather than wrapping on an over-grant
        // one credit per grant cycle
        if (bus.credit_gnt && cred != {CREDIT_W{1'b1}}) begin
            cred = cred + 1'b1;
        end

        if (take) begin
            next_st.valid = 1'b1;
            next_st.data = src_data;
            next_st.user[`CCRX_START_LSB +: 2] = src_start_flags;
            next_st.user[`CCRX_FIRST_POS_BIT] = src_first_pos;
            next_st.user[`CCRX_SECOND_POS_BIT] = src_second_pos;
            next_st.user[`CCRX_END_LSB +: 2] = src_end_flags;
            next_st.user[`CCRX_ABORT_LSB +: 2] = src_abort;
            next_st.user[`CCRX_END0_OFF_LSB +: 3] = src_end0_offset;
            next_st.user[`CCRX_END1_OFF_LSB +: 3] = src_end1_offset;
            next_st.user[`CCRX_PARITY_LSB +: `CCRX_BYTES] = src_par;
            if (cred >= CREDIT_W'(starts)) begin
                cred = cred - CREDIT_W'(starts);
            end else begin
                cred = '0;
            end
            open_sum = {2'h0, st.open_pkt} + {1'b0, starts};
            wide_open = (open_sum > {1'b0, ends});
            next_st.open_pkt = wide_open;
        end

        case (st.link)
            ccrx_pkg::CCRX_STOP: begin
                if (link_enable && !bus.deact_hint) begin
                    next_st.link = ccrx_pkg::CCRX_REQ;
                end
            end
            ccrx_pkg::CCRX_REQ: begin
                if (bus.deact_hint || !link_enable) begin
                    next_st.link = ccrx_pkg::CCRX_RETURN;
                end else if (bus.active_ack) begin
                    next_st.link = ccrx_pkg::CCRX_ACTIVE;
                end
            end
            ccrx_pkg::CCRX_ACTIVE: begin
                if (bus.deact_hint || !link_enable) begin
                    next_st.link = ccrx_pkg::CCRX_DRAIN;
                end
            end
            ccrx_pkg::CCRX_DRAIN: begin
                // Finish the open packet before handing credits back
                if (!next_st.open_pkt) begin
                    next_st.link = ccrx_pkg::CCRX_RETURN;
                end
            end
            ccrx_pkg::CCRX_RETURN: begin
                next_st.credit_rtn = 1'b1;
                cred = '0;
                next_st.open_pkt = 1'b0;
                next_st.link = ccrx_pkg::CCRX_STOP;
            end
            default: begin
                next_st.link = ccrx_pkg::CCRX_STOP;
            end
        endcase
        next_st.credits = cred;
        // Registered so the link output comes from a flop
        next_st.link_up = (next_st.link == ccrx_pkg::CCRX_ACTIVE);

        // request held through the active period
        next_st.active_req = (next_st.link == ccrx_pkg::CCRX_REQ) || link_flowing(next_st.link);

        // new packets only with two credits in hand
        // a continuation beat starts at most one packet.
        // Limitation: a drain that runs out of credits waits for a freed one
        next_st.src_ready = 1'b0;
        if (next_st.open_pkt && link_flowing(next_st.link)) begin
            next_st.src_ready = (cred != '0);
        end else if (next_st.link == ccrx_pkg::CCRX_ACTIVE) begin
            next_st.src_ready = (cred >= CREDIT_W'(2));
        end
    end

    always_ff @(posedge mclk) begin
        // Reset leaves the link stopped with no credits held
        if (sys_rst) begin
            st <= '0;
            st.link <= ccrx_pkg::CCRX_STOP;
            st.credits <= CREDIT_W'(`CCRX_CREDIT_RST);
        end else begin
            st <= next_st;
        end
    end

    assign bus.rx_data = st.data;
    // abort only rides a valid beat
    assign bus.rx_user = st.user;
    assign bus.rx_valid = st.valid;
    assign bus.credit_rtn = st.credit_rtn;
    assign bus.active_req = st.active_req;
    assign src_ready = st.src_ready;
    assign link_active = st.link_up;
    assign credit_level = st.credits;
endmodule // ccrx_device

`default_nettype wire

//--- shared/ccrx_defines.svh
// Constants of the 256-bit receive packet stream: widths, sideband field positions,
// start and end codes, credit sizes and reset values. Definitions only.
`ifndef CCRX_DEFINES_SVH
`define CCRX_DEFINES_SVH

`define CCRX_DATA_W 256
`define CCRX_BYTES 32
// Parity field 45:14 needs 46 sideband bits
`define CCRX_USER_W 46
`define CCRX_START_LSB 0
`define CCRX_FIRST_POS_BIT 2
`define CCRX_SECOND_POS_BIT 3
`define CCRX_END_LSB 4
`define CCRX_ABORT_LSB 6
`define CCRX_END0_OFF_LSB 8
`define CCRX_END1_OFF_LSB 11
`define CCRX_PARITY_LSB 14
`define CCRX_CODE_NONE 2'h0
`define CCRX_CODE_ONE 2'h1
`define CCRX_CODE_TWO 2'h3
`define CCRX_CODE_RSVD 2'h2
`define CCRX_CREDIT_W 8
`define CCRX_APP_CREDITS 8'h08
`define CCRX_CREDIT_RST 8'h00

`endif

//--- shared/ccrx_pkg.sv
// Types shared by both ends of the receive packet stream.
// Assumes ccrx_defines.svh is on the include path.
`include "ccrx_defines.svh"

package ccrx_pkg;

    typedef enum logic [2:0] {
        CCRX_STOP,
        CCRX_REQ,
        CCRX_ACTIVE,
        CCRX_DRAIN,
        CCRX_RETURN
    } ccrx_link_t;

    typedef struct packed {
        ccrx_link_t link;
        logic [`CCRX_CREDIT_W-1:0] credits;
        logic open_pkt;
        logic src_ready;
        logic valid;
        logic [`CCRX_DATA_W-1:0] data;
        logic [`CCRX_USER_W-1:0] user;
        logic active_req;
        logic credit_rtn;
        logic link_up;
    } ccrx_dev_state_t;

    typedef struct packed {
        logic [`CCRX_CREDIT_W-1:0] free;
        logic gnt;
        logic ack;
        logic hint;
        logic tainted;
        logic pkt_valid;
        logic [`CCRX_DATA_W-1:0] pkt_data;
        logic [1:0] pkt_start_flags;
        logic [1:0] pkt_end_flags;
        logic pkt_drop;
        logic parity_error;
    } ccrx_app_state_t;

endpackage

//--- shared/ccrx_if.sv
// Receive packet stream between the core end and the application end.
// Both ends run on the same clock; the testbench instantiates it.
`timescale 1ns/100ps
`default_nettype none
`include "ccrx_defines.svh"

interface ccrx_if;
    logic [`CCRX_DATA_W-1:0] rx_data;
    logic [`CCRX_USER_W-1:0] rx_user;
    logic rx_valid;
    logic credit_gnt;
    logic credit_rtn;
    logic active_req;
    logic active_ack;
    logic deact_hint;

    modport dev (
        output rx_data, rx_user, rx_valid, credit_rtn, active_req,
        input credit_gnt, active_ack, deact_hint
    );
    modport app (
        input rx_data, rx_user, rx_valid, credit_rtn, active_req,
        output credit_gnt, active_ack, deact_hint
    );
endinterface // ccrx_if

`default_nettype wire

//--- hdl/ccrx_app.sv
// Application end of the receive packet stream: grants credits, answers
// activation, checks parity and nullifies aborted or corrupted packets.
// Assumes one clock shared with the core end and a synchronous reset.
`timescale 1ns/100ps
`default_nettype none
`include "ccrx_defines.svh"

module ccrx_app #(
    parameter logic [`CCRX_CREDIT_W-1:0] CREDITS = `CCRX_APP_CREDITS
) (
    input wire logic mclk, // Clock
    input wire logic sys_rst, // Sync reset, high
    ccrx_if.app bus, // Stream from core
    input wire logic app_ready, // Able to accept packets
    input wire logic want_reset, // Request link reset
    input wire logic buf_release, // One buffer freed
    output logic pkt_valid, // Beat delivered
    output logic [`CCRX_DATA_W-1:0] pkt_data, // Beat data
    output logic [1:0] pkt_start_flags, // Start code
    output logic [1:0] pkt_end_flags, // End code
    output logic pkt_drop, // Ending packet nullified
    output logic parity_error // Parity mismatch seen
);
    ccrx_pkg::ccrx_app_state_t st;
    ccrx_pkg::ccrx_app_state_t next_st;
    logic [`CCRX_BYTES-1:0] calc_par;

    genvar gi;
    generate
        for (gi = 0; gi < `CCRX_BYTES; gi++) begin : g_par
            assign calc_par[gi] = ~^bus.rx_data[gi*8 +: 8];
        end
    endgenerate

    always_comb begin
        logic err;
        logic abort;
        logic [1:0] ends;
        err = 1'b0;
        abort = 1'b0;
        ends = 2'h0;
        next_st = st;
        next_st.pkt_valid = bus.rx_valid;
        next_st.pkt_drop = 1'b0;
        next_st.parity_error = 1'b0;
        // Count down as each grant is issued, so no extra grant slips out
        // all credits then each freed one
        next_st.gnt = 1'b0;
        if (st.ack && st.free != '0) begin
            next_st.gnt = 1'b1;
            next_st.free = st.free - 1'b1;
        end
        if (buf_release && next_st.free != CREDITS) begin
            next_st.free = next_st.free + 1'b1;
        end
        if (bus.credit_rtn) begin
            next_st.free = CREDITS;
            next_st.gnt = 1'b0;
        end
        next_st.ack = bus.active_req && app_ready && !want_reset;
        next_st.hint = want_reset;
        if (bus.rx_valid) begin
            err = (bus.rx_user[`CCRX_PARITY_LSB +: `CCRX_BYTES] != calc_par);
            abort = |bus.rx_user[`CCRX_ABORT_LSB +: 2];
            ends = bus.rx_user[`CCRX_END_LSB +: 2];
            next_st.pkt_data = bus.rx_data;
            next_st.pkt_start_flags = bus.rx_user[`CCRX_START_LSB +: 2];
            next_st.pkt_end_flags = ends;
            next_st.parity_error = err;
            next_st.pkt_drop = (ends != `CCRX_CODE_NONE) && (st.tainted || abort || err);
            next_st.tainted = (ends == `CCRX_CODE_NONE) && (st.tainted || abort || err);
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            st <= '0;
            st.free <= CREDITS;
        end else begin
            st <= next_st;
        end
    end

    assign bus.credit_gnt = st.gnt;
    assign bus.active_ack = st.ack;
    assign bus.deact_hint = st.hint;
    assign pkt_valid = st.pkt_valid;
    assign pkt_data = st.pkt_data;
    assign pkt_start_flags = st.pkt_start_flags;
    assign pkt_end_flags = st.pkt_end_flags;
    assign pkt_drop = st.pkt_drop;
    assign parity_error = st.parity_error;
endmodule // ccrx_app

`default_nettype wire

//--- verification/ccrx_checker.sv
// Assertions on the receive stream between the core end and the application end.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/100ps
`default_nettype none
`include "ccrx_defines.svh"

module ccrx_checker (
    input wire logic mclk, // Clock
    input wire logic sys_rst, // Sync reset
    input wire logic [`CCRX_DATA_W-1:0] rx_data, // Beat data
    input wire logic [`CCRX_USER_W-1:0] rx_user, // Sideband
    input wire logic rx_valid, // Beat valid
    input wire logic credit_gnt, // Credit grant
    input wire logic credit_rtn, // Credit return
    input wire logic active_req, // Activation request
    input wire logic active_ack, // Activation acknowledge
    input wire logic deact_hint // Deactivation hint
);
    logic [31:0] par;
    int cnt;
    int starts;

    default clocking @(posedge mclk); endclocking
    default disable iff (sys_rst);

    always_comb begin
        for (int i = 0; i < `CCRX_BYTES; i++) begin
            par[i] = ~^rx_data[8*i+:8];
        end
    end

    assign starts = !rx_valid ? 0 : (rx_user[1:0] == 2'h3) ? 2 : int'(rx_user[1:0] == 2'h1);

    // Grants seen minus starts delivered; core hands all back on return
    always_ff @(posedge mclk) begin
        if (sys_rst || credit_rtn) begin
            cnt <= 0;
        end else begin
            cnt <= cnt + int'(credit_gnt) - starts;
        end
    end

    sequence hint_up_s;
        $rose(deact_hint) && active_req;
    endsequence
    sequence rtn_soon_s;
        ##[1:40] credit_rtn;
    endsequence

    idle_user_a: assert property (!rx_valid |-> rx_user == '0) else $error("sideband set while idle");
    abort_valid_a: assert property (rx_user[7:6] != 2'h0 |-> rx_valid) else $error("abort without valid");
    parity_odd_a: assert property (rx_valid |-> rx_user[45:14] == par) else $error("parity bits wrong");
    start_code_a: assert property (rx_valid |-> rx_user[1:0] != 2'h2) else $error("reserved start code");
    credit_hold_a: assert property (rx_valid |-> cnt >= starts) else $error("beat without credit");
    rtn_pulse_a: assert property (credit_rtn |=> !credit_rtn) else $error("return not one pulse");
    hint_return_a: assert property (hint_up_s |-> rtn_soon_s) else $error("hint not answered");
    req_hold_a: assert property ($fell(active_req) |-> ##1 credit_rtn)
        else $error("request dropped early");
    ack_after_req_a: assert property (active_ack |-> $past(active_req))
        else $error("ack without request");
    gnt_after_ack_a: assert property (credit_gnt |-> $past(active_ack))
        else $error("grant without ack");
    valid_link_a: assert property (rx_valid |-> active_req || $past(active_req))
        else $error("beat with link down");
endmodule // ccrx_checker

`default_nettype wire

//--- verification/tb_top.sv
// Testbench joining the core end and the application end of the receive stream.
// Assumes the shared package, interface, both ends and the checker are compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "ccrx_defines.svh"

module tb_top;
    typedef struct packed {
        logic [255:0] data;
        logic [1:0] start;
        logic fpos;
        logic spos;
        logic [1:0] endc;
        logic [2:0] e0;
        logic [2:0] e1;
        logic [1:0] abort;
        logic drop;
    } ccrx_row_t;

    logic mclk = 0;
    logic sys_rst = 1;
    logic link_enable = 0;
    logic src_valid = 0;
    logic app_ready = 0;
    logic want_reset = 0;
    logic buf_release = 0;
    ccrx_row_t cur = '0;
    ccrx_row_t rows [6];
    logic src_ready, link_active, pkt_valid, pkt_drop, parity_error;
    logic [`CCRX_CREDIT_W-1:0] credit_level;
    logic [255:0] pkt_data;
    logic [1:0] pkt_start_flags, pkt_end_flags;
    int n_mismatch = 0;
    int check_count = 0;
    int k;

    always #5 mclk = ~mclk;

    ccrx_if bus ();
    ccrx_device i_ccrx_device (.mclk(mclk), .sys_rst(sys_rst), .bus(bus), .link_enable(link_enable),
        .src_valid(src_valid), .src_ready(src_ready), .src_data(cur.data), .src_start_flags(cur.start),
        .src_first_pos(cur.fpos), .src_second_pos(cur.spos), .src_end_flags(cur.endc),
        .src_end0_offset(cur.e0), .src_end1_offset(cur.e1), .src_abort(cur.abort),
        .link_active(link_active), .credit_level(credit_level));
    ccrx_app i_ccrx_app (.mclk(mclk), .sys_rst(sys_rst), .bus(bus), .app_ready(app_ready), .want_reset(want_reset),
        .buf_release(buf_release), .pkt_valid(pkt_valid), .pkt_data(pkt_data), .pkt_start_flags(pkt_start_flags),
        .pkt_end_flags(pkt_end_flags), .pkt_drop(pkt_drop), .parity_error(parity_error));
    ccrx_checker i_ccrx_checker (.mclk(mclk), .sys_rst(sys_rst), .rx_data(bus.rx_data), .rx_user(bus.rx_user),
        .rx_valid(bus.rx_valid), .credit_gnt(bus.credit_gnt), .credit_rtn(bus.credit_rtn),
        .active_req(bus.active_req), .active_ack(bus.active_ack), .deact_hint(bus.deact_hint));

    task automatic complete_run();
        if (n_mismatch == 0 && check_count > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    task automatic chk(input logic ok, input string msg);
        check_count++;
        if (ok !== 1'b1) begin
            n_mismatch++;
            $display("CHECK FAILED %0t %s", $time, msg);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask

    function automatic logic [45:0] exp_user(input ccrx_row_t r);
        logic [31:0] p;
        for (int i = 0; i < 32; i++) begin
            p[i] = ~^r.data[8*i+:8];
        end
        return {p, r.e1, r.e0, r.abort, r.endc, r.spos, r.fpos, r.start};
    endfunction

    // One beat, held until taken, then its two views checked
    task automatic send(input ccrx_row_t r);
        cur = r;
        src_valid = 1;
        for (k = 0; k < 30 && src_ready !== 1'b1; k++) tick(1);
        tick(1);
        src_valid = 0;
        chk(bus.rx_valid === 1'b1 && bus.rx_data === r.data, "beat data");
        chk(bus.rx_user === exp_user(r), "beat sideband");
        tick(1);
        chk(pkt_valid === 1'b1 && pkt_data === r.data && pkt_drop === r.drop, "app view");
        chk(pkt_start_flags === r.start && pkt_end_flags === r.endc, "app flags");
        chk(parity_error === 1'b0, "parity clean");
        chk(bus.rx_valid === 1'b0, "single beat");
    endtask

    // Limit well above the expected run of under a hundred cycles
    initial begin
        #200000;
        n_mismatch++;
        complete_run();
    end

    initial begin
        rows[0] = '{{8{32'h0123_4567}}, 2'h1, 1'b0, 1'b0, 2'h1, 3'h7, 3'h0, 2'h0, 1'b0};
        rows[1] = '{{8{32'h8000_00ff}}, 2'h3, 1'b0, 1'b1, 2'h3, 3'h3, 3'h7, 2'h0, 1'b0};
        rows[2] = '{{32{8'h01}}, 2'h1, 1'b1, 1'b0, 2'h0, 3'h0, 3'h0, 2'h0, 1'b0};
        rows[3] = '{{16{16'hfe03}}, 2'h0, 1'b0, 1'b0, 2'h0, 3'h0, 3'h0, 2'h1, 1'b0};
        rows[4] = '{{256{1'b1}}, 2'h0, 1'b0, 1'b0, 2'h1, 3'h5, 3'h0, 2'h0, 1'b1};
        rows[5] = '{256'h0, 2'h1, 1'b0, 1'b0, 2'h1, 3'h2, 3'h0, 2'h3, 1'b1};
        tick(12);
        sys_rst = 0;
        chk(bus.active_req === 1'b0 && link_active === 1'b0 && credit_level === 8'h00, "reset state");
        link_enable = 1;
        app_ready = 1;
        for (k = 0; k < 40 && credit_level !== `CCRX_APP_CREDITS; k++) tick(1);
        chk(link_active === 1'b1 && bus.active_req === 1'b1 && bus.active_ack === 1'b1, "link up");
        chk(credit_level === `CCRX_APP_CREDITS, "all credits granted");
        foreach (rows[i]) send(rows[i]);
        chk(credit_level === 8'h03, "credits used");
        send(rows[0]);
        send(rows[0]);
        // Held beat refused with a single credit
        src_valid = 1;
        for (k = 0; k < 6; k++) begin
            tick(1);
            chk(src_ready === 1'b0 && bus.rx_valid === 1'b0 && credit_level === 8'h01, "gated");
        end
        buf_release = 1;
        tick(1);
        buf_release = 0;
        send(rows[0]);
        chk(credit_level === 8'h01, "freed credit used");
        want_reset = 1;
        for (k = 0; k < 40 && bus.credit_rtn !== 1'b1; k++) tick(1);
        chk(bus.credit_rtn === 1'b1 && credit_level === 8'h00 && link_active === 1'b0, "credits returned");
        tick(1);
        chk(bus.credit_rtn === 1'b0 && bus.active_req === 1'b0, "deactivated");
        want_reset = 0;
        for (k = 0; k < 40 && credit_level !== `CCRX_APP_CREDITS; k++) tick(1);
        chk(link_active === 1'b1 && credit_level === `CCRX_APP_CREDITS, "relinked");
        send(rows[1]);
        complete_run();
    end
endmodule // tb_top

`default_nettype wire
